// >>> hw/rwrb_top.sv
// Runtime wake register block: relocatable 16-byte I/O window and wake logic.
// Assumes i_rst is the standby-rail power-on reset; host-bus reset does not touch it.
// Assumes host cycles arrive as address, data and one-cycle strobes on i_clk_sys.
// Assumes polarity, drive type, base and printer power are set outside this block.
// Functional notes
// - Decode address bits 11:4 against base, require bits 15:12 zero.
// - Base below 0x100 disables all decoding of the block.
// - Reserved bits read as zero.
// - Wake registers reset to zero only on standby power-on reset.
// - Summary flag sets when any status bit and its enable are one.
// - Writing one clears summary flag and releases wake output; zero ignored.
// - Global enable bit zero forbids wake output; one permits it.
// - Status bits set on source events regardless of any enable.
// - Status one bits 0-7 map general pins 10-17.
// - Status two: ring one, ring two, pins 20-24; bit 7 reserved.
// - Status three bits 0-7 map general pins 30-37.
// - Writing one clears a status bit; zero keeps it.
// - Printer irq bit reads one while port unpowered, else follows ack.
// - Registers sit at offsets from the configured block base.
// - Pin wake edge rising by default, falling when polarity inverted.
// - Wake output active low by default; polarity and drive selectable.
// - Wake output asserts only with summary flag and global enable set.
// - Ring indicator assertions (falling edges of the active-low inputs) are wake events setting their status bits.
`timescale 1ns/1ps
`default_nettype none
module rwrb_top (
    // Clock and standby power-on reset.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Host I/O cycle and block base.
    input wire rwrb_pkg::rwrb_io_req_t i_io,
    input wire logic [11:0] i_block_base_cfg,
    // Wake sources.
    input wire logic [7:0] i_gen_pin_10,
    input wire logic [4:0] i_gen_pin_20,
    input wire logic [7:0] i_gen_pin_30,
    input wire logic i_ring_indicate_one_n,
    input wire logic i_ring_indicate_two_n,
    input wire logic [20:0] i_pin_polarity_inv,
    // Printer port status inputs.
    input wire logic i_printer_ack_in,
    input wire logic i_printer_port_power,
    // Wake output configuration.
    input wire rwrb_pkg::rwrb_out_cfg_t i_wake_cfg,
    // Host read answer.
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_hit,
    // Wake output pin.
    output logic o_wake_event_out,
    output logic o_wake_event_out_oe
);
    import rwrb_pkg::*;

    // Address decode of the current host cycle.
    logic hit;
    logic [3:0] ofs;
    logic wr;

    // One-hot write strobes for the wake registers.
    logic wr_summary;
    logic wr_global_en;
    logic wr_status_one;
    logic wr_status_two;
    logic wr_status_three;
    logic wr_enable_one;
    logic wr_enable_two;
    logic wr_enable_three;

    // Wake source pins in status order, edge selects and edge pulses.
    logic [NUM_SOURCES-1:0] pin_raw;
    logic [NUM_SOURCES-1:0] pin_fall;
    logic [NUM_SOURCES-1:0] edge_evt;

    // Per-source wake status registers.
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] st3;

    // Per-source wake enable registers.
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] en3;

    // Summary flag and global enable.
    logic wake_summary_flag;
    logic wake_global_en;

    // Management status and enable storage.
    logic [7:0] mgmt_st1;
    logic [7:0] mgmt_st2;
    logic [7:0] mgmt_en1;
    logic [7:0] mgmt_en2;

    // Pin data storage.
    logic [7:0] pd1;
    logic [7:0] pd2;
    logic [7:0] pd3;
    logic [7:0] pd4;

    // Printer acknowledge and port power synchronisers.
    logic prn_s1;
    logic prn_s2;
    logic prn_s3;
    logic pwr_s1;
    logic pwr_s2;
    logic pwr_s3;

    // Printer interrupt state, wake gating and read mux.
    logic printer_port_irq;
    logic any_pending;
    logic wake_active;
    logic [7:0] next_rdata;

    // Base bits 3:0 are ignored, so an unaligned base decodes its enclosing window.
    // full 16-bit address qualification
    assign hit = (i_io.addr[15:12] == UPPER_ZERO) && (i_block_base_cfg >= BASE_MIN)
        && (i_io.addr[11:4] == i_block_base_cfg[11:4]);
    assign ofs = i_io.addr[3:0];
    assign wr = hit && i_io.wr;

    // Per-register write strobes; a claimed write at offsets 0-7 selects exactly one.
    assign wr_summary = wr && (ofs == OFS_WAKE_SUMMARY);
    assign wr_global_en = wr && (ofs == OFS_WAKE_GLOBAL_EN);
    assign wr_status_one = wr && (ofs == OFS_WAKE_STATUS_ONE);
    assign wr_status_two = wr && (ofs == OFS_WAKE_STATUS_TWO);
    assign wr_status_three = wr && (ofs == OFS_WAKE_STATUS_THREE);
    assign wr_enable_one = wr && (ofs == OFS_WAKE_ENABLE_ONE);
    assign wr_enable_two = wr && (ofs == OFS_WAKE_ENABLE_TWO);
    assign wr_enable_three = wr && (ofs == OFS_WAKE_ENABLE_THREE);

    // Source order: status one, then status two, then status three.
    // Slot 15 is the reserved bit of status two and never produces an edge.
    // ring inputs inverted, active low
    assign pin_raw = {i_gen_pin_30, 1'b0, i_gen_pin_20, ~i_ring_indicate_two_n,
        ~i_ring_indicate_one_n, i_gen_pin_10};
    assign pin_fall = {i_pin_polarity_inv[20:13], 1'b0, i_pin_polarity_inv[12:8],
        1'b0, 1'b0, i_pin_polarity_inv[7:0]};

    // A level must be sampled on two clocks to be seen; shorter glitches may be lost.
    // each input synchronised then edge detected
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SOURCES; gi++) begin : g_src
            rwrb_sync_edge u_se (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_pin(pin_raw[gi]),
                .i_falling(pin_fall[gi]),
                .o_edge(edge_evt[gi])
            );
        end
    endgenerate

    rwrb_wake_bank #(.VALID_MASK(8'hff)) u_bank1 (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_event(edge_evt[7:0]),
        .i_wr_status(wr_status_one),
        .i_wr_enable(wr_enable_one),
        .i_wdata(i_io.wdata),
        .o_status(st1),
        .o_enable(en1)
    );

    // rings and pins 20-24, bit 7 reserved
    rwrb_wake_bank #(.VALID_MASK(MASK_STATUS_TWO)) u_bank2 (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_event(edge_evt[15:8]),
        .i_wr_status(wr_status_two),
        .i_wr_enable(wr_enable_two),
        .i_wdata(i_io.wdata),
        .o_status(st2),
        .o_enable(en2)
    );

    rwrb_wake_bank #(.VALID_MASK(8'hff)) u_bank3 (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_event(edge_evt[23:16]),
        .i_wr_status(wr_status_three),
        .i_wr_enable(wr_enable_three),
        .i_wdata(i_io.wdata),
        .o_status(st3),
        .o_enable(en3)
    );

    // Any source with both status and enable set.
    assign any_pending = |{st1 & en1, st2 & en2, st3 & en3};

    // Set has priority, so a clear written while a source is pending is lost.
    // Software clears the status bits first, then the summary flag.
    // summary set independent of global enable
    // write one clears, pending set wins
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wake_summary_flag <= 1'b0;
        end else if (any_pending) begin
            wake_summary_flag <= 1'b1;
        end else if (wr_summary && i_io.wdata[0]) begin
            wake_summary_flag <= 1'b0;
        end
    end

    // Global enable register.
    // Only bit 0 is stored; the reserved bits read back as zero.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wake_global_en <= 1'b0;
        end else if (wr_global_en) begin
            wake_global_en <= i_io.wdata[0];
        end
    end

    // Management and pin data registers, plain storage here.
    // Their bit meanings lie outside this block, so all eight bits are kept.
    // Bit 0 of management status two is replaced on read by the printer state.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            mgmt_st1 <= RST_ZERO;
            mgmt_st2 <= RST_MGMT_STATUS_TWO;
            mgmt_en1 <= RST_ZERO;
            mgmt_en2 <= RST_ZERO;
            pd1 <= RST_ZERO;
            pd2 <= RST_ZERO;
            pd3 <= RST_ZERO;
            pd4 <= RST_ZERO;
        end else if (wr) begin
            case (ofs)
                OFS_MGMT_IRQ_STATUS_ONE: mgmt_st1 <= i_io.wdata;
                OFS_MGMT_IRQ_STATUS_TWO: mgmt_st2 <= i_io.wdata;
                OFS_MGMT_IRQ_ENABLE_ONE: mgmt_en1 <= i_io.wdata;
                OFS_MGMT_IRQ_ENABLE_TWO: mgmt_en2 <= i_io.wdata;
                OFS_PIN_DATA_ONE: pd1 <= i_io.wdata;
                OFS_PIN_DATA_TWO: pd2 <= i_io.wdata;
                OFS_PIN_DATA_THREE: pd3 <= i_io.wdata;
                OFS_PIN_DATA_FOUR: pd4 <= i_io.wdata;
                default: ;
            endcase
        end
    end

    // Printer inputs come from pins and pass three flops.
    // Power settles once its last two flops agree; acknowledge is taken only while both its pair and the power pair agree.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prn_s1 <= 1'b0;
            prn_s2 <= 1'b0;
            prn_s3 <= 1'b0;
            pwr_s1 <= 1'b0;
            pwr_s2 <= 1'b0;
            pwr_s3 <= 1'b0;
        end else begin
            prn_s1 <= i_printer_ack_in;
            prn_s2 <= prn_s1;
            prn_s3 <= prn_s2;
            pwr_s1 <= i_printer_port_power;
            pwr_s2 <= pwr_s1;
            pwr_s3 <= pwr_s2;
        end
    end

    // A value is taken only when the last two flops agree, which hides metastable samples.
    // one while unpowered, else ack
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            printer_port_irq <= 1'b1;
        end else if (pwr_s2 == pwr_s3) begin
            printer_port_irq <= pwr_s3 ? ((prn_s2 == prn_s3) ? prn_s3 : printer_port_irq) : 1'b1;
        end
    end

    // Read mux for the claimed offset; the default branch returns zero.
    // reserved bits read zero
    always_comb begin
        next_rdata = RST_ZERO;
        case (ofs)
            OFS_WAKE_SUMMARY: next_rdata = {7'h00, wake_summary_flag} & MASK_BIT0;
            OFS_WAKE_GLOBAL_EN: next_rdata = {7'h00, wake_global_en} & MASK_BIT0;
            OFS_WAKE_STATUS_ONE: next_rdata = st1;
            OFS_WAKE_STATUS_TWO: next_rdata = st2 & MASK_STATUS_TWO;
            OFS_WAKE_STATUS_THREE: next_rdata = st3;
            OFS_WAKE_ENABLE_ONE: next_rdata = en1;
            OFS_WAKE_ENABLE_TWO: next_rdata = en2 & MASK_STATUS_TWO;
            OFS_WAKE_ENABLE_THREE: next_rdata = en3;
            OFS_MGMT_IRQ_STATUS_ONE: next_rdata = mgmt_st1;
            OFS_MGMT_IRQ_STATUS_TWO: begin
                next_rdata = mgmt_st2;
                next_rdata[PRN_IRQ_BIT] = printer_port_irq;
            end
            OFS_MGMT_IRQ_ENABLE_ONE: next_rdata = mgmt_en1;
            OFS_MGMT_IRQ_ENABLE_TWO: next_rdata = mgmt_en2;
            OFS_PIN_DATA_ONE: next_rdata = pd1;
            OFS_PIN_DATA_TWO: next_rdata = pd2;
            OFS_PIN_DATA_THREE: next_rdata = pd3;
            OFS_PIN_DATA_FOUR: next_rdata = pd4;
            default: next_rdata = RST_ZERO;
        endcase
    end

    // Read answer one cycle after the strobe; zero when not claimed.
    // Zero data outside a claimed read lets several answers share one host path.
    // The hit pulse also follows writes, so the host sees that the cycle was claimed.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= RST_ZERO;
            o_rvalid <= 1'b0;
            o_hit <= 1'b0;
        end else begin
            o_rdata <= (hit && i_io.rd) ? next_rdata : RST_ZERO;
            o_rvalid <= hit && i_io.rd;
            o_hit <= hit && (i_io.rd || i_io.wr);
        end
    end

    // The sticky summary keeps the pin asserted until software clears it.
    // global enable gates output
    assign wake_active = wake_global_en && wake_summary_flag;

    // Open drain drives only a low level; during reset the pin is released.
    // The chipset pull-up then sets the idle level of the line.
    // active low default, selectable polarity and drive
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_wake_event_out <= 1'b0;
            o_wake_event_out_oe <= 1'b0;
        end else begin
            o_wake_event_out <= i_wake_cfg.active_high ? wake_active : ~wake_active;
            o_wake_event_out_oe <= i_wake_cfg.push_pull ||
                (i_wake_cfg.active_high ? ~wake_active : wake_active);
        end
    end
endmodule
`default_nettype wire

// >>> hw/rwrb_pkg.sv
// Package for the runtime wake register block: offsets, layouts, reset values.
// Assumes byte-wide host I/O cycles and a 16-bit I/O address.
package rwrb_pkg;

    // Register offsets within the 16-byte block.
    localparam logic [3:0] OFS_WAKE_SUMMARY = 4'h0;
    localparam logic [3:0] OFS_WAKE_GLOBAL_EN = 4'h1;
    localparam logic [3:0] OFS_WAKE_STATUS_ONE = 4'h2;
    localparam logic [3:0] OFS_WAKE_STATUS_TWO = 4'h3;
    localparam logic [3:0] OFS_WAKE_STATUS_THREE = 4'h4;
    localparam logic [3:0] OFS_WAKE_ENABLE_ONE = 4'h5;
    localparam logic [3:0] OFS_WAKE_ENABLE_TWO = 4'h6;
    localparam logic [3:0] OFS_WAKE_ENABLE_THREE = 4'h7;
    localparam logic [3:0] OFS_MGMT_IRQ_STATUS_ONE = 4'h8;
    localparam logic [3:0] OFS_MGMT_IRQ_STATUS_TWO = 4'h9;
    localparam logic [3:0] OFS_MGMT_IRQ_ENABLE_ONE = 4'ha;
    localparam logic [3:0] OFS_MGMT_IRQ_ENABLE_TWO = 4'hb;
    localparam logic [3:0] OFS_PIN_DATA_ONE = 4'hc;
    localparam logic [3:0] OFS_PIN_DATA_TWO = 4'hd;
    localparam logic [3:0] OFS_PIN_DATA_THREE = 4'he;
    localparam logic [3:0] OFS_PIN_DATA_FOUR = 4'hf;

    // Address decode limits.
    localparam logic [11:0] BASE_MIN = 12'h100;
    localparam logic [3:0] UPPER_ZERO = 4'h0;

    // Reset values and field masks.
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_MGMT_STATUS_TWO = 8'h01;
    localparam logic [7:0] MASK_BIT0 = 8'h01;
    localparam logic [7:0] MASK_STATUS_TWO = 8'h7f;
    localparam int PRN_IRQ_BIT = 0;
    localparam int NUM_SOURCES = 24;

    // One byte-wide host I/O cycle.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } rwrb_io_req_t;

    // Pin configuration bits for the wake output.
    typedef struct packed {
        logic active_high;
        logic push_pull;
    } rwrb_out_cfg_t;

endpackage

// >>> hw/rwrb_sync_edge.sv
// Three-flop synchroniser with edge detection for one wake source pin.
// Assumes the pin is asynchronous to i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
module rwrb_sync_edge (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Pin and edge select.
    input wire logic i_pin,
    input wire logic i_falling,
    // Edge pulse.
    output logic o_edge
);
    import rwrb_pkg::*;

    logic s1;
    logic s2;
    logic s3;
    logic lvl;

    // Pin passes three flops; the last two are compared for a settled level.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Last accepted level; it moves only once the last two flops agree.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            lvl <= 1'b0;
        end else if (s2 == s3) begin
            lvl <= s3;
        end
    end

    // Selected edge only, one cycle wide: a settled level that differs from the last one.
    assign o_edge = (s2 == s3) && (s3 != lvl) && (i_falling ? ~s3 : s3);
endmodule
`default_nettype wire

// >>> hw/rwrb_wake_bank.sv
// One 8-bit wake status register with its enable register.
// Assumes edge pulses are already synchronous and one cycle wide.
`timescale 1ns/1ps
`default_nettype none
module rwrb_wake_bank #(
    parameter logic [7:0] VALID_MASK = 8'hff
) (
    // Clock and standby reset.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Events and host writes.
    input wire logic [7:0] i_event,
    input wire logic i_wr_status,
    input wire logic i_wr_enable,
    input wire logic [7:0] i_wdata,
    // Register contents.
    output logic [7:0] o_status,
    output logic [7:0] o_enable
);
    import rwrb_pkg::*;

    logic [7:0] clr;

    assign clr = i_wr_status ? i_wdata : RST_ZERO;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_status <= RST_ZERO;
        end else begin
            o_status <= ((o_status & ~clr) | i_event) & VALID_MASK;
        end
    end

    // Enable bits are plain read/write; reserved bits stay zero.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_enable <= RST_ZERO;
        end else if (i_wr_enable) begin
            o_enable <= i_wdata & VALID_MASK;
        end
    end
endmodule
`default_nettype wire

// >>> dv/rwrb_chk.sv
// Port checker for the runtime wake register block.
// Assumes a bind onto rwrb_top; one clock and one reset domain.
`timescale 1ns/1ps
`default_nettype none
module rwrb_chk (
    // Clock and standby reset.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Host cycle and configuration.
    input wire rwrb_pkg::rwrb_io_req_t i_io,
    input wire logic [11:0] i_block_base_cfg,
    input wire rwrb_pkg::rwrb_out_cfg_t i_wake_cfg,
    // Design answers.
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_hit,
    input wire logic o_wake_event_out,
    input wire logic o_wake_event_out_oe
);
    import rwrb_pkg::*;
    logic claim;
    logic wake_on;
    logic gen_q;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // Claimed access and the driven active level of the wake pin.
    assign claim = (i_io.rd | i_io.wr) && i_io.addr[15:12] == UPPER_ZERO
        && i_block_base_cfg >= BASE_MIN && i_io.addr[11:4] == i_block_base_cfg[11:4];
    assign wake_on = o_wake_event_out_oe && (o_wake_event_out == i_wake_cfg.active_high);
    // Shadow of the global enable, taken from claimed writes.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            gen_q <= 1'b0;
        end else if (claim && i_io.wr && i_io.addr[3:0] == OFS_WAKE_GLOBAL_EN) begin
            gen_q <= i_io.wdata[0];
        end
    end
    sequence s_rd_claim;
        claim && i_io.rd;
    endsequence
    sequence s_answer;
        o_rvalid && o_hit;
    endsequence
    property p_read_answer;
        s_rd_claim |=> s_answer;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("claimed read not answered");
    property p_no_claim;
        !claim |=> !o_hit;
    endproperty
    a_no_claim: assert property (p_no_claim) else $error("hit without claim");
    property p_low_base;
        (i_io.rd || i_io.wr) && i_block_base_cfg < BASE_MIN |=> !o_hit && o_rdata == 8'h00;
    endproperty
    a_low_base: assert property (p_low_base) else $error("low base decoded");
    property p_write_hit;
        claim && i_io.wr |=> o_hit && !o_rvalid;
    endproperty
    a_write_hit: assert property (p_write_hit) else $error("write answer wrong");
    property p_idle_rdata;
        !o_rvalid |-> o_rdata == 8'h00;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside answer");
    property p_enable_rsvd;
        s_rd_claim ##0 (i_io.addr[3:1] == 3'h0) |=> o_rdata[7:1] == 7'h00;
    endproperty
    a_enable_rsvd: assert property (p_enable_rsvd) else $error("reserved bits set");
    property p_status_two_rsvd;
        s_rd_claim ##0 (i_io.addr[3:0] == OFS_WAKE_STATUS_TWO) |=> !o_rdata[7];
    endproperty
    a_status_two_rsvd: assert property (p_status_two_rsvd) else $error("status two bit 7 set");
    property p_global_off;
        !gen_q && !$past(gen_q) && $stable(i_wake_cfg) |-> !wake_on;
    endproperty
    a_global_off: assert property (p_global_off) else $error("wake driven while disabled");
    property p_wake_cause;
        $rose(wake_on) && $stable(i_wake_cfg) |-> $past(gen_q);
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake rose without enable");
endmodule
`default_nettype wire

// >>> dv/rwrb_src_model.sv
// Wake sources and the chipset end of the wake line.
// Assumes a pull-up on the wake line; flips are called off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module rwrb_src_model (
    // Wake pin from the design.
    input wire logic i_out,
    input wire logic i_oe,
    // Source pins.
    output logic [20:0] o_gen_pin,
    output logic [1:0] o_ring_n,
    // Resolved wake line.
    output logic o_wake_line
);
    assign o_wake_line = i_oe ? i_out : 1'b1;
    // Pins idle low, ring inputs idle high.
    initial begin
        o_gen_pin = '0;
        o_ring_n = 2'b11;
    end
    task automatic flip(input int idx);
        if (idx < 21) begin
            o_gen_pin[idx] = ~o_gen_pin[idx];
        end else begin
            o_ring_n[idx - 21] = ~o_ring_n[idx - 21];
        end
    endtask
endmodule
`default_nettype wire

// >>> dv/tb_runtime_wake_register_block.sv
// Self-checking bench for the runtime wake register block.
// Assumes rwrb_top, rwrb_chk and rwrb_src_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_runtime_wake_register_block;
    import rwrb_pkg::*;
    logic i_clk_sys, i_rst, ack, pwr, rvalid, hit, wout, woe, wline, hq, vq;
    rwrb_io_req_t io;
    rwrb_out_cfg_t cfg;
    logic [11:0] base;
    logic [20:0] pins, pol;
    logic [1:0] ring_n;
    logic [7:0] rdata, q, d;
    logic [7:0] mdl [16];
    int n_fail, compares, r, b;
    int rwo[11] = '{1, 5, 6, 7, 8, 10, 11, 12, 13, 14, 15};
    rwrb_top i_rwrb_top (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_io(io), .i_block_base_cfg(base),
        .i_gen_pin_10(pins[7:0]), .i_gen_pin_20(pins[12:8]), .i_gen_pin_30(pins[20:13]),
        .i_ring_indicate_one_n(ring_n[0]), .i_ring_indicate_two_n(ring_n[1]), .i_pin_polarity_inv(pol),
        .i_printer_ack_in(ack), .i_printer_port_power(pwr), .i_wake_cfg(cfg), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_hit(hit), .o_wake_event_out(wout), .o_wake_event_out_oe(woe));
    rwrb_src_model i_rwrb_src_model (.i_out(wout), .i_oe(woe), .o_gen_pin(pins), .o_ring_n(ring_n),
        .o_wake_line(wline));
    // Free-running system clock.
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    task automatic stop_test;
        $display("fails %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One byte cycle; the answer is taken one edge later.
    task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] wd);
        @(negedge i_clk_sys);
        io = '{addr: a, wdata: wd, rd: !w, wr: w};
        @(negedge i_clk_sys);
        io.rd = 1'b0;
        io.wr = 1'b0;
        q = rdata;
        hq = hit;
        vq = rvalid;
    endtask
    task automatic wr(input logic [3:0] o, input logic [7:0] wd);
        acc({4'h0, base[11:4], o}, 1'b1, wd);
    endtask
    task automatic rd(input logic [3:0] o, input logic [7:0] e);
        acc({4'h0, base[11:4], o}, 1'b0, 8'h00);
        chk({7'h0, hq}, 8'h01);
        chk({7'h0, vq}, 8'h01);
        chk(q, e);
    endtask
    task automatic ev(input int s);
        @(negedge i_clk_sys);
        i_rwrb_src_model.flip(s);
        repeat (8) @(negedge i_clk_sys);
    endtask
    task automatic wline_is(input logic e);
        for (int k = 0; k < 12 && wline !== e; k++) @(negedge i_clk_sys);
        chk({7'h0, wline}, {7'h0, e});
        if (wline !== e) stop_test();
    endtask
    function automatic logic [7:0] msk(input int o);
        return o == 1 ? 8'h01 : (o == 6 ? 8'h7f : 8'hff);
    endfunction
    // Main sequence.
    initial begin
        void'($urandom(32'h38bbc24f));
        io = '0;
        base = 12'h100;
        pol = 21'($urandom);
        pol[3] = 1'b0;
        {ack, pwr, cfg, n_fail, compares} = '0;
        i_rst = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        i_rst = 1'b0;
        for (int o = 0; o < 16; o++) rd(4'(o), o == 9 ? 8'h01 : 8'h00);
        // aligned base in the legal range
        base = {8'($urandom_range(16, 255)), 4'h0};
        for (int k = 0; k < 11; k++) begin
            d = 8'($urandom);
            wr(4'(rwo[k]), d);
            mdl[rwo[k]] = d & msk(rwo[k]);
            rd(4'(rwo[k]), mdl[rwo[k]]);
        end
        acc({4'h1, base[11:4], 4'h5}, 1'b1, ~mdl[5]);
        chk({7'h0, hq}, 8'h00);
        rd(4'h5, mdl[5]);
        d = base[11:4];
        base = 12'h0f0;
        acc(16'h00f5, 1'b0, 8'h00);
        chk(q, 8'h00);
        chk({6'h0, vq, hq}, 8'h00);
        base = {d, 4'h0};
        wr(4'h1, 8'h00);
        wr(4'h5, 8'h08);
        wr(4'h6, 8'h00);
        wr(4'h7, 8'h00);
        ev(3);
        rd(4'h2, 8'h08);
        rd(4'h0, 8'h01);
        chk({7'h0, wline}, 8'h01);
        wr(4'h1, 8'h01);
        wline_is(1'b0);
        wr(4'h2, 8'h00);
        rd(4'h2, 8'h08);
        wr(4'h2, 8'h08);
        rd(4'h2, 8'h00);
        ev(3);
        rd(4'h2, 8'h00);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h00);
        wline_is(1'b1);
        wr(4'h1, 8'h00);
        wr(4'h5, 8'h00);
        {mdl[2], mdl[3], mdl[4]} = '0;
        for (int s = 0; s < 23; s++) begin
            if (s < 8) begin
                r = 2;
                b = s;
            end else if (s < 13) begin
                r = 3;
                b = s - 6;
            end else if (s < 21) begin
                r = 4;
                b = s - 13;
            end else begin
                r = 3;
                b = s - 21;
            end
            if (s < 21 && pol[s]) ev(s);
            ev(s);
            mdl[r][b] = 1'b1;
            rd(4'(r), mdl[r]);
        end
        rd(4'h0, 8'h00);
        wr(4'h7, 8'h80);
        rd(4'h0, 8'h01);
        cfg = '{active_high: 1'b1, push_pull: 1'b1};
        wr(4'h1, 8'h01);
        wline_is(1'b1);
        for (int o = 2; o < 5; o++) wr(4'(o), 8'hff);
        wr(4'h0, 8'h01);
        wline_is(1'b0);
        pwr = 1'b1;
        for (int k = 0; k < 2; k++) begin
            ack = ~ack;
            repeat (5) @(negedge i_clk_sys);
            rd(4'h9, {7'h0, ack});
        end
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        i_rst = 1'b0;
        for (int k = 0; k < 11; k++) rd(4'(rwo[k]), 8'h00);
        stop_test();
    end
    // Guard against a hang.
    initial begin
        #1500000;
        n_fail++;
        stop_test();
    end
endmodule
bind rwrb_top rwrb_chk i_rwrb_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_io(i_io),
    .i_block_base_cfg(i_block_base_cfg), .i_wake_cfg(i_wake_cfg), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_hit(o_hit), .o_wake_event_out(o_wake_event_out), .o_wake_event_out_oe(o_wake_event_out_oe));
`default_nettype wire
